/* File: verilog/reload_timer_consts.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * reload timer. Assumes inclusion by the timer package and design modules.
 */
`ifndef RELOAD_TIMER_CONSTS_SVH
`define RELOAD_TIMER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (printed offsets); the byte address is the index times four
// ----------------------------------------------------------------------
`define IDX_RELOAD_LOW      8'h55
`define IDX_RELOAD_HIGH     8'h56
`define IDX_COUNT_LOW       8'h57
`define IDX_COUNT_HIGH      8'h58
`define IDX_TIMER_CONTROL   8'h59
`define IDX_IRQ_CONTROL     8'h5a
`define IDX_IRQ_STATUS      8'h5b

// ----------------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------------
`define BIT_LOW_IRQ_EN      5
`define BIT_CAPTURE_EN      4
`define BIT_RUN             2
`define BIT_SOURCE_SEL      0
`define CTRL_WRITE_MASK     8'h35
`define BIT_TIMER_IRQ_EN    0
`define BIT_OVF_FLAG        0
`define BIT_LOW_OVF_FLAG    1

// ----------------------------------------------------------------------
// Reset values and dividers
// ----------------------------------------------------------------------
`define RESET_BYTE          8'h00
`define SYS_DIVIDE          4'd12
`define OSC_DIVIDE          3'd7
`endif

/* File: verilog/reload_timer_pkg.sv */
/*
 * Types shared by the reload timer modules.
 * Assumes the constants header is on the include path.
 */
package reload_timer_pkg;
    `include "reload_timer_consts.svh"

    // --------------------------------------------------------------
    // Bus slave states
    // --------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_DONE
    } bus_state_t;

    typedef logic [7:0] byte_t;
endpackage

/* File: verilog/osc_tick_gen.sv */
/*
 * Oscillator edge detector and divide-by-8 tick generator.
 * Assumes osc_in is asynchronous to the core clock and much slower.
 */
`include "reload_timer_consts.svh"
module osc_tick_gen
    import reload_timer_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic osc_in,
    output logic      osc_tick
);
    logic       sync1_ff;
    logic       sync2_ff;
    logic       prev_ff;
    logic [2:0] cnt_ff;

    // Two-stage synchroniser; only sync2 feeds logic
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= osc_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Eight rising edges make one tick
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_ff   <= 3'd0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= 1'b0;
            if (sync2_ff && !prev_ff) begin
                cnt_ff <= cnt_ff + 3'd1;
                if (cnt_ff == `OSC_DIVIDE) begin
                    osc_tick <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: verilog/reload_timer.sv */
/*
 * 16-bit auto-reload timer with oscillator capture, APB register slave.
 * Assumes a 50 MHz CORE_CLK, synchronous active-low RSTN and a slow
 * asynchronous oscillator on OSC_IN.
 */
// Decided for this implementation: the APB slave port.
`include "reload_timer_consts.svh"

// What this block does
// - Control bit 5 enables low-byte overflow interrupts when timer interrupts enabled.
// - Control bit 4 selects oscillator capture mode instead of auto-reload.
// - Control bit 2 runs the counter; cleared, the count holds.
// - Source bit 0 clear: count ticks at system clock divided by 12.
// - Source bit 0 set: count ticks at oscillator divided by 8.
// - Control bits 7:6 and 3 read zero, writes ignored.
// - Control bit 1 reads zero, writes ignored.
// - Reload low register holds reload bits 7:0, read and write.
// - Reload high register holds reload upper byte, read and write.
// - Counter is 16 bits, visible as low and high byte registers.
// - Tick increments; outside capture mode, wrap from all ones loads reload, sets overflow flag.
// - Each 16-bit overflow outside capture mode interrupts when timer interrupts enabled.
// - Capture mode: every eighth oscillator cycle copy count to reload, flag.
module reload_timer
    import reload_timer_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        OSC_IN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    byte_t      reload_low_ff;
    byte_t      reload_high_ff;
    byte_t      count_low_ff;
    byte_t      count_high_ff;
    byte_t      control_ff;
    logic       timer_irq_en_ff;
    logic       ovf_flag_ff;
    logic       low_ovf_flag_ff;
    logic [3:0] prescale_ff;
    logic       sys_tick_ff;
    bus_state_t bus_state_ff;
    logic       osc_tick;
    logic       tick;
    logic       wr_acc;
    logic       rd_acc;
    logic       hit;
    logic [9:0] widx;
    logic       low_wrap;
    logic       full_wrap;
    logic       capture;
    byte_t      nxt_low;
    byte_t      nxt_high;

    // Register index decode used by read and write paths
    function automatic logic [9:0] word_index(input logic [11:0] a);
        return a[11:2];
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        logic [9:0] i;
        i = a[11:2];
        return (a[1:0] == 2'b00) && (i >= 10'(`IDX_RELOAD_LOW)) && (i <= 10'(`IDX_IRQ_STATUS));
    endfunction

    // ------------------------------------------------------------------
    // Tick sources
    // ------------------------------------------------------------------
    osc_tick_gen u_osc (
        .clk      (CORE_CLK),
        .rstn     (RSTN),
        .osc_in   (OSC_IN),
        .osc_tick (osc_tick)
    );

    // Divide by 12 prescaler; free running so the phase is independent of run
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            prescale_ff <= 4'd0;
            sys_tick_ff <= 1'b0;
        end else if (prescale_ff == `SYS_DIVIDE - 4'd1) begin
            prescale_ff <= 4'd0;
            sys_tick_ff <= 1'b1;
        end else begin
            prescale_ff <= prescale_ff + 4'd1;
            sys_tick_ff <= 1'b0;
        end
    end

    // Source select picks the counting tick
    assign tick = control_ff[`BIT_SOURCE_SEL] ? osc_tick : sys_tick_ff;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Refused addresses never reach a register, misaligned aliases included
    assign wr_acc = PSEL && PENABLE && PWRITE && (bus_state_ff == BUS_IDLE) && hit;
    assign rd_acc = PSEL && PENABLE && !PWRITE && (bus_state_ff == BUS_IDLE);
    assign hit    = is_mapped(PADDR);
    assign widx   = word_index(PADDR);

    // ------------------------------------------------------------------
    // Counter datapath
    // ------------------------------------------------------------------
    // Capture mode counts the source-selected tick; the oscillator tick also samples
    assign capture   = control_ff[`BIT_CAPTURE_EN] && osc_tick;
    assign low_wrap  = control_ff[`BIT_RUN] && tick && (count_low_ff == 8'hff);
    assign full_wrap = low_wrap && (count_high_ff == 8'hff);

    always_comb begin
        nxt_low  = count_low_ff;
        nxt_high = count_high_ff;
        if (control_ff[`BIT_RUN] && tick) begin
            if (full_wrap && !control_ff[`BIT_CAPTURE_EN]) begin
                nxt_low  = reload_low_ff;
                nxt_high = reload_high_ff;
            end else begin
                {nxt_high, nxt_low} = 16'({count_high_ff, count_low_ff} + 16'd1);
            end
        end
        // Software write wins over a tick in the same cycle
        if (wr_acc && widx == 10'(`IDX_COUNT_LOW)) begin
            nxt_low = PWDATA[7:0];
        end
        if (wr_acc && widx == 10'(`IDX_COUNT_HIGH)) begin
            nxt_high = PWDATA[7:0];
        end
    end

    // Count bytes
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            count_low_ff  <= `RESET_BYTE;
            count_high_ff <= `RESET_BYTE;
        end else begin
            count_low_ff  <= nxt_low;
            count_high_ff <= nxt_high;
        end
    end

    // Reload bytes; capture overrides a same-cycle write so no sample is lost
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            reload_low_ff  <= `RESET_BYTE;
            reload_high_ff <= `RESET_BYTE;
        end else if (capture) begin
            reload_low_ff  <= count_low_ff;
            reload_high_ff <= count_high_ff;
        end else if (wr_acc) begin
            if (widx == 10'(`IDX_RELOAD_LOW)) begin
                reload_low_ff <= PWDATA[7:0];
            end
            if (widx == 10'(`IDX_RELOAD_HIGH)) begin
                reload_high_ff <= PWDATA[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Unused bits are masked on write so they always read zero
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            control_ff      <= `RESET_BYTE;
            timer_irq_en_ff <= 1'b0;
        end else if (wr_acc) begin
            if (widx == 10'(`IDX_TIMER_CONTROL)) begin
                control_ff <= PWDATA[7:0] & `CTRL_WRITE_MASK;
            end
            if (widx == 10'(`IDX_IRQ_CONTROL)) begin
                timer_irq_en_ff <= PWDATA[`BIT_TIMER_IRQ_EN];
            end
        end
    end

    // ------------------------------------------------------------------
    // Event flags: write one to clear, a new event wins over the clear
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ovf_flag_ff     <= 1'b0;
            low_ovf_flag_ff <= 1'b0;
        end else begin
            if (full_wrap && !control_ff[`BIT_CAPTURE_EN] || capture) begin
                ovf_flag_ff <= 1'b1;
            end else if (wr_acc && widx == 10'(`IDX_IRQ_STATUS) && PWDATA[`BIT_OVF_FLAG]) begin
                ovf_flag_ff <= 1'b0;
            end
            if (low_wrap) begin
                low_ovf_flag_ff <= 1'b1;
            end else if (wr_acc && widx == 10'(`IDX_IRQ_STATUS) && PWDATA[`BIT_LOW_OVF_FLAG]) begin
                low_ovf_flag_ff <= 1'b0;
            end
        end
    end

    // Interrupt line is a level of pending enabled flags
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= timer_irq_en_ff && (ovf_flag_ff
                   || (low_ovf_flag_ff && control_ff[`BIT_LOW_IRQ_EN]));
        end
    end

    // ------------------------------------------------------------------
    // APB answer: one wait state, ready on the second access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            bus_state_ff <= BUS_IDLE;
            PREADY       <= 1'b0;
            PSLVERR      <= 1'b0;
            PRDATA       <= 32'h0000_0000;
        end else begin
            case (bus_state_ff)
                BUS_IDLE: begin
                    if (PSEL && PENABLE) begin
                        bus_state_ff <= BUS_DONE;
                        PREADY       <= 1'b1;
                        PSLVERR      <= !hit;
                        PRDATA       <= 32'h0000_0000;
                        if (rd_acc && hit) begin
                            case (widx)
                                10'(`IDX_RELOAD_LOW):    PRDATA[7:0] <= reload_low_ff;
                                10'(`IDX_RELOAD_HIGH):   PRDATA[7:0] <= reload_high_ff;
                                10'(`IDX_COUNT_LOW):     PRDATA[7:0] <= count_low_ff;
                                10'(`IDX_COUNT_HIGH):    PRDATA[7:0] <= count_high_ff;
                                10'(`IDX_TIMER_CONTROL): PRDATA[7:0] <= control_ff;
                                10'(`IDX_IRQ_CONTROL):   PRDATA[0]   <= timer_irq_en_ff;
                                10'(`IDX_IRQ_STATUS):    PRDATA[1:0] <= {low_ovf_flag_ff, ovf_flag_ff};
                                default:                 PRDATA      <= 32'h0000_0000;
                            endcase
                        end
                    end
                end
                BUS_DONE: begin
                    bus_state_ff <= BUS_IDLE;
                    PREADY       <= 1'b0;
                    PSLVERR      <= 1'b0;
                end
                default: begin
                    bus_state_ff <= BUS_IDLE;
                    PREADY       <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_wrap;
        control_ff[`BIT_RUN] && tick && !control_ff[`BIT_CAPTURE_EN]
        && {count_high_ff, count_low_ff} == 16'hffff && !wr_acc;
    endsequence

    AST_RELOAD_ON_WRAP: assert property (s_wrap |=> {count_high_ff, count_low_ff} ==
        $past({reload_high_ff, reload_low_ff}) && ovf_flag_ff)
        else $error("counter did not reload on wrap");

    AST_HOLD_WHEN_STOPPED: assert property (!control_ff[`BIT_RUN] && !wr_acc |=>
        $stable({count_high_ff, count_low_ff}))
        else $error("counter moved while stopped");

    AST_INCREMENT: assert property (control_ff[`BIT_RUN] && tick && !wr_acc && count_low_ff != 8'hff
        |=> count_low_ff == $past(count_low_ff) + 8'd1)
        else $error("counter did not increment");

    AST_SYS_TICK_PERIOD: assert property (sys_tick_ff |=> !sys_tick_ff [*8] ##1 !sys_tick_ff [*3] ##1 sys_tick_ff)
        else $error("system tick not every 12 cycles");

    AST_OSC_TICK_SELECT: assert property (control_ff[`BIT_SOURCE_SEL] && control_ff[`BIT_RUN] && !osc_tick
        && !wr_acc |=> $stable({count_high_ff, count_low_ff}))
        else $error("oscillator source not selected");

    AST_CTRL_UNUSED_ZERO: assert property ((control_ff & ~`CTRL_WRITE_MASK) == 8'h00)
        else $error("unused control bit set");

    AST_CTRL_BIT1_ZERO: assert property (control_ff[1] == 1'b0)
        else $error("control bit 1 set");

    AST_CAPTURE_COPY: assert property (capture |=> {reload_high_ff, reload_low_ff} ==
        $past({count_high_ff, count_low_ff}) && ovf_flag_ff)
        else $error("capture did not copy counter");

    AST_LOW_BYTE_IRQ: assert property (low_wrap && timer_irq_en_ff && control_ff[`BIT_LOW_IRQ_EN]
        && !wr_acc |=> ##1 IRQ)
        else $error("low byte overflow did not interrupt");

    AST_OVF_IRQ: assert property (ovf_flag_ff && timer_irq_en_ff |=> IRQ)
        else $error("overflow did not interrupt");

    AST_LOW_FLAG: assert property (low_wrap |=> low_ovf_flag_ff)
        else $error("low byte flag not set");

    AST_COUNT_WRITE: assert property (wr_acc && widx == 10'(`IDX_COUNT_LOW) |=>
        count_low_ff == $past(PWDATA[7:0]))
        else $error("count low write lost");

    AST_RELOAD_WRITE: assert property (wr_acc && !capture && widx == 10'(`IDX_RELOAD_HIGH) |=>
        reload_high_ff == $past(PWDATA[7:0]))
        else $error("reload high write lost");

    AST_RELOAD_LOW_WRITE: assert property (wr_acc && !capture && widx == 10'(`IDX_RELOAD_LOW) |=>
        reload_low_ff == $past(PWDATA[7:0]))
        else $error("reload low write lost");

    AST_CAPTURE_ENABLE: assert property (control_ff[`BIT_CAPTURE_EN] && full_wrap && !wr_acc |=>
        {count_high_ff, count_low_ff} == 16'h0000)
        else $error("capture mode reloaded counter");

    // Interrupts stay quiet while the master enable is off
    AST_IRQ_GATED: assert property (!timer_irq_en_ff |=> !IRQ)
        else $error("interrupt raised while disabled");

    // A pending low-byte flag alone stays silent without its own enable
    AST_LOW_IRQ_MASKED: assert property (!ovf_flag_ff && !control_ff[`BIT_LOW_IRQ_EN] |=> !IRQ)
        else $error("low byte flag interrupted while masked");

    AST_COUNT_HIGH_WRITE: assert property (wr_acc && widx == 10'(`IDX_COUNT_HIGH) |=>
        count_high_ff == $past(PWDATA[7:0]))
        else $error("count high write lost");

    AST_LOW_CARRY: assert property (low_wrap && !full_wrap && !wr_acc |=> count_low_ff == 8'h00
        && count_high_ff == $past(count_high_ff) + 8'd1)
        else $error("low byte wrap did not carry");
endmodule

/* File: test/reload_timer_bench.sv */
/*
 * Self-checking bench for the reload timer: APB register accesses,
 * counting from both sources, overflow and reload, low-byte flag, capture.
 * Assumes the timer package and constants header are compiled alongside.
 */
`include "reload_timer_consts.svh"

module reload_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk;
    logic        rstn;
    logic        osc_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    int          fail_count;
    int          compares;
    logic [31:0] rdata;
    logic        rerr;

    reload_timer dut (
        .CORE_CLK (core_clk),
        .RSTN     (rstn),
        .OSC_IN   (osc_in),
        .PSEL     (psel),
        .PENABLE  (penable),
        .PWRITE   (pwrite),
        .PADDR    (paddr),
        .PWDATA   (pwdata),
        .PRDATA   (prdata),
        .PREADY   (pready),
        .PSLVERR  (pslverr),
        .IRQ      (irq)
    );

    // ------------------------------------------------------------
    // Clock, verdict and comparisons
    // ------------------------------------------------------------
    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Single exit point for pass, fail and hang
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Tick boundaries make the exact count uncertain by one
    task automatic check_near(input string what, input int lo, input int hi, input logic [31:0] got);
        compares++;
        if ($isunknown(got) || !(got >= lo && got <= hi)) begin
            fail_count++;
            $display("wrong value %s expected %0d..%0d seen %h", what, lo, hi, got);
        end
    endtask

    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    // Request held until PREADY is sampled high; released only after it
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("wrong value pready expected 1 seen %b", pready);
            final_report();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        check(what, exp, rdata);
        check("pslverr", 32'h00000000, {31'h0, rerr});
    endtask

    // Slow oscillator: 10 core cycles per period, then settle time
    task automatic osc_pulses(input int n);
        repeat (n) begin
            repeat (5) @(posedge core_clk);
            osc_in <= 1'b1;
            repeat (5) @(posedge core_clk);
            osc_in <= 1'b0;
        end
        repeat (10) @(posedge core_clk);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        check("irq wait", 32'h00000001, {31'h0, irq});
        if (n >= 300) begin
            final_report();
        end
    endtask

    task automatic irq_after(input logic exp);
        repeat (4) @(posedge core_clk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        compares   = 0;
        rstn    = 1'b0;
        osc_in  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        // Reset values
        rd_chk("reload_low", `IDX_RELOAD_LOW, 32'h00000000);
        rd_chk("reload_high", `IDX_RELOAD_HIGH, 32'h00000000);
        rd_chk("count_low", `IDX_COUNT_LOW, 32'h00000000);
        rd_chk("count_high", `IDX_COUNT_HIGH, 32'h00000000);
        rd_chk("control", `IDX_TIMER_CONTROL, 32'h00000000);
        // Unused control bits read zero
        wr(`IDX_TIMER_CONTROL, 8'hca);
        rd_chk("control unused", `IDX_TIMER_CONTROL, 32'h00000000);
        wr(`IDX_TIMER_CONTROL, 8'h02);
        rd_chk("control bit1", `IDX_TIMER_CONTROL, 32'h00000000);
        wr(`IDX_TIMER_CONTROL, 8'hfb);
        rd_chk("control mask", `IDX_TIMER_CONTROL, 32'h00000031);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        // Reload and count bytes hold what was written
        wr(`IDX_RELOAD_LOW, 8'ha5);
        wr(`IDX_RELOAD_HIGH, 8'h3c);
        rd_chk("reload_low rw", `IDX_RELOAD_LOW, 32'h000000a5);
        rd_chk("reload_high rw", `IDX_RELOAD_HIGH, 32'h0000003c);
        wr(`IDX_COUNT_LOW, 8'h12);
        wr(`IDX_COUNT_HIGH, 8'h34);
        repeat (30) @(posedge core_clk);
        rd_chk("count_low held", `IDX_COUNT_LOW, 32'h00000012);
        rd_chk("count_high rw", `IDX_COUNT_HIGH, 32'h00000034);
        // Unmapped and misaligned accesses are refused
        apb(1'b0, 12'h170, 8'h00);
        check("unmapped err", 32'h00000001, {31'h0, rerr});
        check("unmapped data", 32'h00000000, rdata);
        apb(1'b1, 12'h155, 8'hff);
        check("misaligned err", 32'h00000001, {31'h0, rerr});
        rd_chk("reload_low kept", `IDX_RELOAD_LOW, 32'h000000a5);
        // System clock / 12: about ten ticks in 120 cycles
        wr(`IDX_COUNT_LOW, 8'h00);
        wr(`IDX_COUNT_HIGH, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h04);
        repeat (117) @(posedge core_clk);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        apb(1'b0, {2'b00, `IDX_COUNT_LOW, 2'b00}, 8'h00);
        check_near("count sys ticks", 9, 11, rdata);
        // 16-bit wrap reloads and raises the overflow flag
        wr(`IDX_RELOAD_LOW, 8'h34);
        wr(`IDX_RELOAD_HIGH, 8'h12);
        wr(`IDX_COUNT_LOW, 8'hfe);
        wr(`IDX_COUNT_HIGH, 8'hff);
        wr(`IDX_IRQ_CONTROL, 8'h01);
        irq_after(1'b0);
        wr(`IDX_TIMER_CONTROL, 8'h04);
        wait_irq();
        wr(`IDX_TIMER_CONTROL, 8'h00);
        rd_chk("count_high reload", `IDX_COUNT_HIGH, 32'h00000012);
        rd_chk("status wrap", `IDX_IRQ_STATUS, 32'h00000003);
        wr(`IDX_IRQ_STATUS, 8'h03);
        rd_chk("status cleared", `IDX_IRQ_STATUS, 32'h00000000);
        irq_after(1'b0);
        // Low byte wrap alone: flag set, interrupt only with its enable
        wr(`IDX_COUNT_LOW, 8'hfe);
        wr(`IDX_COUNT_HIGH, 8'h12);
        wr(`IDX_TIMER_CONTROL, 8'h04);
        repeat (40) @(posedge core_clk);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        rd_chk("count_high carry", `IDX_COUNT_HIGH, 32'h00000013);
        rd_chk("status low wrap", `IDX_IRQ_STATUS, 32'h00000002);
        irq_after(1'b0);
        wr(`IDX_TIMER_CONTROL, 8'h20);
        irq_after(1'b1);
        wr(`IDX_IRQ_STATUS, 8'h03);
        irq_after(1'b0);
        // Oscillator / 8 as count source
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_COUNT_LOW, 8'h00);
        wr(`IDX_COUNT_HIGH, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h05);
        repeat (60) @(posedge core_clk);
        rd_chk("count no osc", `IDX_COUNT_LOW, 32'h00000000);
        osc_pulses(16);
        rd_chk("count osc ticks", `IDX_COUNT_LOW, 32'h00000002);
        // Capture copies the held count into the reload bytes
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_COUNT_LOW, 8'hef);
        wr(`IDX_COUNT_HIGH, 8'hbe);
        wr(`IDX_TIMER_CONTROL, 8'h10);
        rd_chk("control capture", `IDX_TIMER_CONTROL, 32'h00000010);
        osc_pulses(8);
        rd_chk("capture low", `IDX_RELOAD_LOW, 32'h000000ef);
        rd_chk("capture high", `IDX_RELOAD_HIGH, 32'h000000be);
        rd_chk("capture flag", `IDX_IRQ_STATUS, 32'h00000001);
        check("capture irq", 32'h00000001, {31'h0, irq});
        // Capture mode running: wrap goes to zero, no reload, no overflow flag
        wr(`IDX_IRQ_STATUS, 8'h03);
        wr(`IDX_COUNT_LOW, 8'hfe);
        wr(`IDX_COUNT_HIGH, 8'hff);
        wr(`IDX_TIMER_CONTROL, 8'h14);
        repeat (40) @(posedge core_clk);
        wr(`IDX_TIMER_CONTROL, 8'h00);
        rd_chk("capture wrap high", `IDX_COUNT_HIGH, 32'h00000000);
        rd_chk("capture wrap flag", `IDX_IRQ_STATUS, 32'h00000002);
        final_report();
    end
endmodule
